// >>> logic/bdm_core.sv
// Banked data memory addressing, pointers and core special registers.
`timescale 1ns/1ps
`include "bdm_defines.svh"
module bdm_core #(
   parameter int NUM_BANKS = 2,
   parameter logic [7:0] SFR_TOP = `BDM_SFR_TOP
) (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic POR_I,
   input wire logic RST_WDT_PD_I,
   input wire bdm_pkg::bdm_acc_t ACC_REQ_I,
   input wire logic TBL_RD_I,
   input wire logic [15:0] TBL_WORD_I,
   input wire bdm_pkg::bdm_alu_op_t ALU_OP_I,
   input wire logic [7:0] ALU_B_I,
   input wire logic HALT_I,
   input wire logic CLRWDT_I,
   input wire logic WDT_TO_I,
   input wire logic [7:0] PC_LOW_I,
   input wire logic [7:0] EXT_RDATA_I,
   output logic [7:0] RDATA_O,
   output logic [7:0] ACC_O,
   output logic [7:0] STATUS_O,
   output logic [15:0] TBL_ADDR_O,
   output logic PC_JUMP_O,
   output logic [7:0] PC_LOW_O,
   output logic DUMMY_O,
   output logic EXT_RD_O,
   output logic EXT_WR_O,
   output logic [7:0] EXT_ADDR_O,
   output logic [7:0] EXT_WDATA_O
);
   import bdm_pkg::*;

   localparam int BW = (NUM_BANKS > 2) ? 2 : 1;

   logic [7:0] ram [0:NUM_BANKS*256-1];
   logic [7:0] ptr0;
   logic [7:0] ptr1;
   logic [BW-1:0] bank;
   logic [7:0] acc;
   logic [7:0] table_pointer_low;
   logic [7:0] table_pointer_high;
   logic [7:0] table_high_result;
   logic [3:0] arith;
   logic timeout_flag;
   logic powerdown_flag;
   bdm_state_t state;
   bdm_state_t next_state;

   logic is_ind0;
   logic is_ind1;
   logic [7:0] ptr;
   logic [7:0] eff_addr;
   logic [BW-1:0] eff_bank;
   logic self_ind;
   logic in_sfr;
   logic do_wr;
   logic do_rd;
   logic [7:0] wdata;
   logic [7:0] next_rdata;

   // Resolve the indirect ports to the address held by their pointer.
   assign is_ind0 = ACC_REQ_I.addr == `BDM_ADR_IND0;
   assign is_ind1 = ACC_REQ_I.addr == `BDM_ADR_IND1;
   assign ptr = is_ind0 ? ptr0 : ptr1;
   assign eff_addr = (is_ind0 || is_ind1) ? ptr : ACC_REQ_I.addr;
   // Direct and pair-zero accesses are pinned to bank 0.
   assign eff_bank = is_ind1 ? bank : '0;
   assign self_ind = (is_ind0 || is_ind1) &&
      (ptr == `BDM_ADR_IND0 || ptr == `BDM_ADR_IND1);
   // The special area ignores the bank so it is visible from every bank.
   assign in_sfr = eff_addr < SFR_TOP;
   assign do_wr = (ACC_REQ_I.wr || TBL_RD_I) && !self_ind;
   assign do_rd = ACC_REQ_I.rd && !self_ind;
   // A table read stores its low byte at the instruction's destination.
   assign wdata = TBL_RD_I ? TBL_WORD_I[7:0] : ACC_REQ_I.wdata;

   // Peripheral registers of the special area are served outside.
   assign EXT_ADDR_O = eff_addr;
   assign EXT_WDATA_O = wdata;
   assign EXT_WR_O = do_wr && in_sfr && eff_addr > `BDM_ADR_STAT;
   assign EXT_RD_O = do_rd && in_sfr && eff_addr > `BDM_ADR_STAT;

   // Arithmetic unit feeding the accumulator and the arithmetic flags.
   logic [7:0] opb;
   logic cin;
   logic [8:0] sum;
   logic [4:0] lo_sum;
   logic [7:0] hi7;
   logic [7:0] alu_res;
   logic [3:0] alu_flags;
   logic [3:0] alu_mask;
   always_comb begin
      opb = (ALU_OP_I == BDM_OP_SUB) ? ~ALU_B_I : ALU_B_I;
      cin = ALU_OP_I == BDM_OP_SUB;
      sum = {1'b0, acc} + {1'b0, opb} + {8'h00, cin};
      lo_sum = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
      hi7 = {1'b0, acc[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
      alu_res = acc;
      alu_flags = arith;
      alu_mask = 4'h0;
      unique case (ALU_OP_I)
         BDM_OP_NONE: begin
         end
         BDM_OP_ADD, BDM_OP_SUB: begin
            alu_res = sum[7:0];
            alu_flags[`BDM_FLG_C] = sum[8];
            alu_flags[`BDM_FLG_AC] = lo_sum[4];
            alu_flags[`BDM_FLG_Z] = sum[7:0] == 8'h00;
            alu_flags[`BDM_FLG_OV] = hi7[7] ^ sum[8];
            alu_mask = 4'hF;
         end
         BDM_OP_AND, BDM_OP_OR: begin
            alu_res = (ALU_OP_I == BDM_OP_AND) ? (acc & ALU_B_I)
                                               : (acc | ALU_B_I);
            alu_flags[`BDM_FLG_Z] = alu_res == 8'h00;
            alu_mask = 4'h4;
         end
         BDM_OP_RLC: begin
            alu_res = {acc[6:0], arith[`BDM_FLG_C]};
            alu_flags[`BDM_FLG_C] = acc[7];
            alu_mask = 4'h1;
         end
         BDM_OP_RRC: begin
            alu_res = {arith[`BDM_FLG_C], acc[7:1]};
            alu_flags[`BDM_FLG_C] = acc[0];
            alu_mask = 4'h1;
         end
      endcase
   end

   // General purpose storage; no reset since its content is undefined.
   always_ff @(posedge CLK_I) begin
      if (do_wr && !in_sfr) begin
         ram[{eff_bank, eff_addr}] <= wdata;
      end
   end

   // Memory pointers behave as ordinary read/write bytes.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         ptr0 <= `BDM_BYTE_RST;
         ptr1 <= `BDM_BYTE_RST;
      end else if (do_wr && eff_addr == `BDM_ADR_PTR0) begin
         ptr0 <= wdata;
      end else if (do_wr && eff_addr == `BDM_ADR_PTR1) begin
         ptr1 <= wdata;
      end
   end

   // A watchdog reset during power down must not lose the bank.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         if (!RST_WDT_PD_I) begin
            bank <= BW'(`BDM_BANK_RST);
         end
      end else if (do_wr && eff_addr == `BDM_ADR_BANK) begin
         bank <= wdata[BW-1:0];
      end
   end

   // Every move between two registers is staged through here.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         acc <= `BDM_BYTE_RST;
      end else if (ALU_OP_I != BDM_OP_NONE) begin
         acc <= alu_res;
      end else if (do_wr && eff_addr == `BDM_ADR_ACC) begin
         acc <= wdata;
      end
   end

   // Table pointer and the high byte of the last table read.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         table_pointer_low <= `BDM_BYTE_RST;
         table_pointer_high <= `BDM_BYTE_RST;
         table_high_result <= `BDM_BYTE_RST;
      end else begin
         if (do_wr && eff_addr == `BDM_ADR_TABLE_POINTER_LOW) begin
            table_pointer_low <= wdata;
         end
         if (do_wr && eff_addr == `BDM_ADR_TABLE_POINTER_HIGH) begin
            table_pointer_high <= wdata;
         end
         if (TBL_RD_I) begin
            table_high_result <= TBL_WORD_I[15:8];
         end
      end
   end
   assign TBL_ADDR_O = {table_pointer_high, table_pointer_low};

   // Arithmetic flags: the unit's update beats a software write.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         arith <= 4'h0;
      end else if (alu_mask != 4'h0) begin
         arith <= (arith & ~alu_mask) | (alu_flags & alu_mask);
      end else if (do_wr && eff_addr == `BDM_ADR_STAT) begin
         arith <= wdata[3:0];
      end
   end

   // System flags ignore writes; a set in the clearing cycle wins.
   // Nothing here pushes status on calls, software saves it.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         if (POR_I) begin
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
         end
      end else begin
         if (WDT_TO_I) begin
            timeout_flag <= 1'b1;
         end else if (CLRWDT_I || HALT_I) begin
            timeout_flag <= 1'b0;
         end
         if (HALT_I) begin
            powerdown_flag <= 1'b1;
         end else if (CLRWDT_I) begin
            powerdown_flag <= 1'b0;
         end
      end
   end

   // Counter low byte write: jump pulse in the same cycle as the one dummy cycle.
   always_comb begin
      next_state = BDM_ST_RUN;
      if (do_wr && eff_addr == `BDM_ADR_PCL) begin
         next_state = BDM_ST_DUMMY;
      end
   end
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         state <= BDM_ST_RUN;
         PC_JUMP_O <= 1'b0;
         PC_LOW_O <= `BDM_BYTE_RST;
      end else begin
         state <= next_state;
         PC_JUMP_O <= next_state == BDM_ST_DUMMY;
         if (next_state == BDM_ST_DUMMY) begin
            PC_LOW_O <= wdata;
         end
      end
   end
   assign DUMMY_O = state == BDM_ST_DUMMY;

   // Read data mux; result appears one cycle after the request.
   always_comb begin
      next_rdata = 8'h00;
      if (self_ind) begin
         next_rdata = `BDM_SELF_RD;
      end else if (!in_sfr) begin
         next_rdata = ram[{eff_bank, eff_addr}];
      end else begin
         unique case (eff_addr)
            `BDM_ADR_PTR0: next_rdata = ptr0;
            `BDM_ADR_PTR1: next_rdata = ptr1;
            `BDM_ADR_BANK: next_rdata = 8'(bank);
            `BDM_ADR_ACC: next_rdata = acc;
            `BDM_ADR_PCL: next_rdata = PC_LOW_I;
            `BDM_ADR_TABLE_POINTER_LOW: next_rdata = table_pointer_low;
            `BDM_ADR_TABLE_HIGH_RESULT: next_rdata = table_high_result;
            `BDM_ADR_TABLE_POINTER_HIGH: next_rdata = table_pointer_high;
            `BDM_ADR_STAT: next_rdata = STATUS_O;
            default: next_rdata = EXT_RDATA_I;
         endcase
      end
   end
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         RDATA_O <= 8'h00;
      end else if (do_rd || (ACC_REQ_I.rd && self_ind)) begin
         RDATA_O <= next_rdata;
      end
   end

   assign ACC_O = acc;
   assign STATUS_O = {2'b00, timeout_flag, powerdown_flag, arith};

   default clocking bdm_cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);

   sequence jump_seq;
      PC_JUMP_O && DUMMY_O ##1 !DUMMY_O;
   endsequence

   self_port_a: assert property (ACC_REQ_I.rd && self_ind |=> RDATA_O == 8'h00)
      else $error("Self-pointing port read not zero.");
   direct_bank_a: assert property (ACC_REQ_I.wr && !TBL_RD_I && !is_ind0
      && !is_ind1 && !in_sfr |=> ram[{BW'(0), $past(ACC_REQ_I.addr)}]
      == $past(ACC_REQ_I.wdata))
      else $error("Direct write missed bank 0.");
   ptr_one_a: assert property (ACC_REQ_I.wr && !TBL_RD_I && is_ind1
      && !in_sfr |=> ram[{$past(bank), $past(ptr1)}]
      == $past(ACC_REQ_I.wdata))
      else $error("Pair one write misplaced.");
   bank_read_a: assert property (ACC_REQ_I.rd && !self_ind
      && eff_addr == `BDM_ADR_BANK |=> RDATA_O == 8'($past(bank)))
      else $error("Bank select read wrong.");
   bank_reset_a: assert property ($rose(RESETN_I) &&
      !$past(RST_WDT_PD_I) |-> bank == '0)
      else $error("Bank not cleared by reset.");
   status_keep_a: assert property (do_wr && eff_addr == `BDM_ADR_STAT
      && !HALT_I && !CLRWDT_I && !WDT_TO_I |=> $stable(STATUS_O[5:4]))
      else $error("Status write changed system flags.");
   pcl_jump_a: assert property (do_wr && eff_addr == `BDM_ADR_PCL
      |=> jump_seq)
      else $error("Counter jump or dummy cycle wrong.");
   add_carry_a: assert property (ALU_OP_I == BDM_OP_ADD |=>
      STATUS_O[0] == ($past({1'b0, acc}) + $past({1'b0, ALU_B_I}) > 9'h0FF))
      else $error("Add carry wrong.");
   zero_flag_a: assert property (ALU_OP_I inside {BDM_OP_ADD, BDM_OP_SUB,
      BDM_OP_AND, BDM_OP_OR} |=> STATUS_O[2] == (acc == 8'h00))
      else $error("Zero flag wrong.");
   pd_flag_a: assert property (HALT_I |=> STATUS_O[4])
      else $error("Halt did not set powerdown flag.");
   to_flag_a: assert property (!WDT_TO_I && (CLRWDT_I || HALT_I)
      |=> !STATUS_O[5])
      else $error("Timeout flag not cleared.");

endmodule : bdm_core

// >>> logic/bdm_defines.svh
// Register offsets, flag positions and reset values of the data memory block.
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH
`define BDM_ADR_IND0 8'h00
`define BDM_ADR_PTR0 8'h01
`define BDM_ADR_IND1 8'h02
`define BDM_ADR_PTR1 8'h03
`define BDM_ADR_BANK 8'h04
`define BDM_ADR_ACC 8'h05
`define BDM_ADR_PCL 8'h06
`define BDM_ADR_TABLE_POINTER_LOW 8'h07
`define BDM_ADR_TABLE_HIGH_RESULT 8'h08
`define BDM_ADR_TABLE_POINTER_HIGH 8'h09
`define BDM_ADR_STAT 8'h0A
`define BDM_SFR_TOP 8'h60
`define BDM_FLG_C 0
`define BDM_FLG_AC 1
`define BDM_FLG_Z 2
`define BDM_FLG_OV 3
`define BDM_FLG_PDF 4
`define BDM_FLG_TO 5
`define BDM_BANK_RST 8'h00
`define BDM_BYTE_RST 8'h00
`define BDM_SELF_RD 8'h00
`endif

// >>> logic/bdm_pkg.sv
// Types shared by the data memory addressing block.
package bdm_pkg;
   // One data memory access from the instruction execution logic.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bdm_acc_t;
   // Arithmetic and logic operations that target the accumulator.
   typedef enum logic [6:0] {
      BDM_OP_NONE = 7'b000_0001,
      BDM_OP_ADD = 7'b000_0010,
      BDM_OP_SUB = 7'b000_0100,
      BDM_OP_AND = 7'b000_1000,
      BDM_OP_OR = 7'b001_0000,
      BDM_OP_RLC = 7'b010_0000,
      BDM_OP_RRC = 7'b100_0000
   } bdm_alu_op_t;
   // Sequencer for program counter low byte jumps.
   typedef enum logic [1:0] {
      BDM_ST_RUN = 2'b01,
      BDM_ST_DUMMY = 2'b10
   } bdm_state_t;
endpackage : bdm_pkg

// >>> dv/bdm_periph_model.sv
// Model of the outside peripheral registers behind the block's strobes.
`timescale 1ns/1ps
module bdm_periph_model (
   input wire logic clk_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [0:255];
   logic [7:0] last;
   initial last = 8'h5A;
   // Writes land on the edge; reads are answered in the same cycle.
   always @(posedge clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
      if (rd_i) begin
         last <= mem[addr_i];
      end
   end
   // An unselected bus shows the inverse of the last value, not stale data.
   assign rdata_o = rd_i ? mem[addr_i] : ~last;
endmodule : bdm_periph_model

// >>> dv/banked_data_memory_addressing_test.sv
// Self-checking testbench of the banked data memory addressing block.
`timescale 1ns/1ps
module banked_data_memory_addressing_test;
   import bdm_pkg::*;
   logic clk, resetn, por, wdt_pd, tbl_rd, halt, clrwdt, wdt_to;
   bdm_acc_t req;
   bdm_alu_op_t op;
   logic [15:0] tbl_word, tbl_addr;
   logic [7:0] alu_b, ext_rdata, rdata, acc, status, pc_low;
   logic [7:0] ext_addr, ext_wdata;
   logic pc_jump, dummy, ext_rd, ext_wr;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;

   bdm_core #(.NUM_BANKS(2)) DUT (.CLK_I(clk), .RESETN_I(resetn),
      .POR_I(por), .RST_WDT_PD_I(wdt_pd), .ACC_REQ_I(req),
      .TBL_RD_I(tbl_rd), .TBL_WORD_I(tbl_word), .ALU_OP_I(op),
      .ALU_B_I(alu_b), .HALT_I(halt), .CLRWDT_I(clrwdt),
      .WDT_TO_I(wdt_to), .PC_LOW_I(8'h12), .EXT_RDATA_I(ext_rdata),
      .RDATA_O(rdata), .ACC_O(acc), .STATUS_O(status),
      .TBL_ADDR_O(tbl_addr), .PC_JUMP_O(pc_jump), .PC_LOW_O(pc_low),
      .DUMMY_O(dummy), .EXT_RD_O(ext_rd), .EXT_WR_O(ext_wr),
      .EXT_ADDR_O(ext_addr), .EXT_WDATA_O(ext_wdata));

   bdm_periph_model partner (.clk_i(clk), .rd_i(ext_rd), .wr_i(ext_wr),
      .addr_i(ext_addr), .wdata_i(ext_wdata), .rdata_o(ext_rdata));

   // Free-running clock at 125 MHz.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // A hang is cut short well past the expected run length.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // Every input is assigned once per falling edge, so no signal is
   // driven twice in one time step between back-to-back operations.
   task automatic step(input logic [17:0] r,
      input bdm_alu_op_t o = BDM_OP_NONE, input logic [7:0] b = 8'h00,
      input logic [2:0] s = 3'b000, input logic t = 1'b0);
      req = r;
      op = o;
      alu_b = b;
      {halt, clrwdt, wdt_to} = s;
      tbl_rd = t;
      @(negedge clk);
   endtask : step

   task automatic wr(input logic [7:0] a, d);
      step({2'b01, a, d});
   endtask : wr

   task automatic rdchk(input logic [7:0] a, e);
      step({2'b10, a, 8'h00});
      chk($sformatf("read %h", a), {8'h00, rdata}, {8'h00, e});
   endtask : rdchk

   task automatic do_reset(input logic p, w);
      resetn = 1'b0;
      por = p;
      wdt_pd = w;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      por = 1'b0;
      wdt_pd = 1'b0;
   endtask : do_reset

   task automatic alu(input bdm_alu_op_t o, input logic [7:0] b,
      input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
      step('0, o, b);
      chk(o.name(), {acc, status} & m, e);
   endtask : alu

   task automatic done(input string n);
      $display("test %s finished", n);
   endtask : done

   task automatic t_bank();
      rdchk(8'h04, 8'h00);
      wr(8'h04, 8'hFF);
      rdchk(8'h04, 8'h01);
      done("bank");
   endtask : t_bank

   task automatic t_ind();
      wr(8'h03, 8'h80);
      wr(8'h02, 8'hA5);
      wr(8'h80, 8'h5A);
      wr(8'h01, 8'h80);
      rdchk(8'h02, 8'hA5);
      rdchk(8'h80, 8'h5A);
      rdchk(8'h00, 8'h5A);
      rdchk(8'h03, 8'h80);
      rdchk(8'h01, 8'h80);
      wr(8'h04, 8'h00);
      rdchk(8'h02, 8'h5A);
      wr(8'h01, 8'h02);
      wr(8'h00, 8'h33);
      rdchk(8'h00, 8'h00);
      rdchk(8'h02, 8'h5A);
      done("indirect");
   endtask : t_ind

   task automatic t_jump();
      wr(8'h06, 8'h34);
      chk("jump", {pc_jump, dummy, pc_low}, {2'b11, 8'h34});
      step('0);
      chk("jump end", {pc_jump, dummy}, 16'h0000);
      rdchk(8'h06, 8'h12);
      done("jump");
   endtask : t_jump

   task automatic t_tbl();
      wr(8'h07, 8'hCD);
      wr(8'h09, 8'hAB);
      chk("table addr", tbl_addr, 16'hABCD);
      tbl_word = 16'hBEEF;
      step({2'b00, 8'h70, 8'h00}, BDM_OP_NONE, 8'h00, 3'b000, 1'b1);
      rdchk(8'h08, 8'hBE);
      rdchk(8'h70, 8'hEF);
      done("table");
   endtask : t_tbl

   // Results reach the accumulator, which is the only path between registers.
   task automatic t_alu();
      wr(8'h05, 8'h7F);
      rdchk(8'h05, 8'h7F);
      alu(BDM_OP_ADD, 8'h01, 16'h800A);
      alu(BDM_OP_ADD, 8'h80, 16'h000D);
      alu(BDM_OP_SUB, 8'h01, 16'hFF00);
      alu(BDM_OP_RLC, 8'h00, 16'hFE01, 16'hFF01);
      alu(BDM_OP_RRC, 8'h00, 16'hFF00, 16'hFF01);
      alu(BDM_OP_AND, 8'h00, 16'h0004, 16'hFF04);
      alu(BDM_OP_OR, 8'h5A, 16'h5A00, 16'hFF04);
      done("alu");
   endtask : t_alu

   task automatic t_sys();
      wr(8'h0A, 8'hFF);
      chk("status wr", status, 16'h000F);
      step('0, BDM_OP_NONE, 8'h00, 3'b100);
      chk("halt", status[5:4], 16'h0001);
      step('0, BDM_OP_NONE, 8'h00, 3'b001);
      chk("timeout", status[5:4], 16'h0003);
      wr(8'h0A, 8'h00);
      chk("status keep", status, 16'h0030);
      wr(8'h04, 8'h01);
      do_reset(1'b0, 1'b1);
      rdchk(8'h04, 8'h01);
      chk("warm reset", status, 16'h0030);
      do_reset(1'b0, 1'b0);
      rdchk(8'h04, 8'h00);
      step('0, BDM_OP_NONE, 8'h00, 3'b010);
      chk("wdt clear", status[5:4], 16'h0000);
      step('0, BDM_OP_NONE, 8'h00, 3'b001);
      step('0, BDM_OP_NONE, 8'h00, 3'b100);
      chk("halt clr", status[5:4], 16'h0001);
      do_reset(1'b1, 1'b0);
      chk("power up", status, 16'h0000);
      done("system");
   endtask : t_sys

   // Only unreserved peripheral places are written from here.
   task automatic t_ext();
      wr(8'h04, 8'h01);
      wr(8'h20, 8'h77);
      rdchk(8'h20, 8'h77);
      wr(8'h03, 8'h20);
      rdchk(8'h02, 8'h77);
      done("peripheral");
   endtask : t_ext

   // Main sequence.
   initial begin
      resetn = 1'b0;
      por = 1'b1;
      wdt_pd = 1'b0;
      req = '0;
      op = BDM_OP_NONE;
      alu_b = 8'h00;
      {halt, clrwdt, wdt_to} = 3'b000;
      tbl_rd = 1'b0;
      tbl_word = 16'h0000;
      @(negedge clk);
      do_reset(1'b1, 1'b0);
      t_bank();
      t_ind();
      t_jump();
      t_tbl();
      t_alu();
      t_sys();
      t_ext();
      stop_test();
   end
endmodule : banked_data_memory_addressing_test
